// >>> hw/link_ctrl_if.sv
`timescale 1ns/100ps
interface link_ctrl_if;
    import lvds_direction_pkg::*;
    logic permit;
    logic grant;
    link_cfg_t req;
    link_cfg_t cfg;
    logic oe;
    modport seq (input permit, input grant, input req, output cfg, output oe);
    modport mgr (output permit, output grant, output req, input cfg, input oe);
endinterface : link_ctrl_if

// >>> hw/link_sequencer.sv
`timescale 1ns/100ps
module link_sequencer
    import lvds_direction_pkg::*;
#(
    parameter int GUARD = GUARD_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    link_ctrl_if.seq link
);
    localparam int CNT_W = $clog2(GUARD + 1);

    if (GUARD < 1) begin : g_check
        $error("guard must be at least one cycle");
    end

    seq_state_t state;
    seq_state_t next_state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    link_cfg_t next_cfg;
    logic next_oe;
    logic keep;

    // ---------------------------------------------------------------
    // break, turn, settle, make
    // ---------------------------------------------------------------
    always_comb begin
        keep = link.permit && link.grant && (link.req == link.cfg);
        next_state = state;
        next_count = count;
        next_cfg = link.cfg;
        next_oe = 1'b0;
        unique case (state)
            SEQ_OFF: begin
                // direction moves only here, where the outputs are already off
                if (link.permit && link.grant) begin
                    next_cfg = link.req;
                    next_count = CNT_W'(GUARD);
                    next_state = SEQ_SETTLE;
                end
            end
            SEQ_SETTLE: begin
                if (!keep) begin
                    next_state = SEQ_OFF;
                end else if (count == '0) begin
                    next_state = SEQ_ON;
                    next_oe = 1'b1;
                end else begin
                    next_count = count - CNT_W'(1);
                end
            end
            SEQ_ON: begin
                if (!keep) begin
                    next_state = SEQ_OFF;
                end else begin
                    next_oe = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SEQ_OFF;
            count <= '0;
            link.cfg <= CFG_RESET;
            link.oe <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            link.cfg <= next_cfg;
            link.oe <= next_oe;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_SEQ_QUIET_TURN:
        assert property ($changed(link.cfg) |-> !link.oe && !$past(link.oe))
        else $error("direction changed while enabled");
    AST_SEQ_GUARD:
        assert property ($rose(link.oe) |-> link.cfg == $past(link.cfg, GUARD + 1))
        else $error("enable came back before guard time");
    AST_SEQ_PERMIT_DROP:
        assert property (!link.permit |=> !link.oe)
        else $error("enable held without permit");
endmodule : link_sequencer

// >>> hw/lvds_direction_manager.sv
`timescale 1ns/100ps
module lvds_direction_manager
    import lvds_direction_pkg::*;
#(
    parameter int CABLES = CABLE_COUNT,
    parameter int TRIGGERS = TRIGGER_COUNT,
    parameter int GUARD = GUARD_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic drive_permit,
    input wire logic base_fpga_configured,
    input wire logic [CABLES-1:0] base_cable_input_request,
    input wire logic [TRIGGERS-1:0] base_trigger_input_request,
    input wire logic topology_fpga_present_n,
    input wire logic topology_fpga_configured,
    input wire logic [TRIGGERS-1:0] topology_trigger_input_request,
    input wire logic vme_acknowledge_request,
    output logic [CABLES-1:0] cable_transceiver_direction,
    output logic [CABLES-1:0] cable_translator_direction,
    output logic [CABLES-1:0] cable_translator_enable_n,
    output logic [TRIGGERS-1:0] trigger_transceiver_direction,
    output logic [TRIGGERS-1:0] trigger_translator_direction,
    output logic [TRIGGERS-1:0] trigger_base_translator_enable_n,
    output logic [TRIGGERS-1:0] trigger_topology_translator_enable_n,
    output logic vme_acknowledge_drive_n,
    output logic vme_transceiver_enable_n,
    output logic vme_address_translator_enable_n,
    output logic timing_decoder_translator_enable_n,
    output logic timing_reset_translator_enable_n
);
    localparam int PIN_W = 4 + CABLES + 2 * TRIGGERS;

    if (CABLES < 1 || CABLES > 4 || TRIGGERS < 1 || TRIGGERS > 2) begin : g_check
        $error("link counts exceed the register layout");
    end

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_sync;
    logic permit_s;
    logic base_done_s;
    logic topo_present_n_s;
    logic topo_done_s;
    logic [CABLES-1:0] base_cable_req_s;
    logic [TRIGGERS-1:0] base_trig_req_s;
    logic [TRIGGERS-1:0] topo_trig_req_s;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {drive_permit, base_fpga_configured, topology_fpga_present_n,
                topology_fpga_configured, base_cable_input_request,
                base_trigger_input_request, topology_trigger_input_request};
            pin_sync <= pin_meta;
        end
    end

    // reset value of the present flag reads as installed but not configured,
    // so the topology side stays ungranted either way
    assign {permit_s, base_done_s, topo_present_n_s, topo_done_s, base_cable_req_s,
        base_trig_req_s, topo_trig_req_s} = pin_sync;

    logic base_ok;
    logic topo_ok;
    assign base_ok = base_done_s;
    assign topo_ok = !topo_present_n_s && topo_done_s;

    // ---------------------------------------------------------------
    // register port
    // ---------------------------------------------------------------
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [31:0] status;
    logic [31:0] next_rdata;

    always_comb begin
        next_ctrl = ctrl;
        if (reg_write && reg_addr == CTRL_ADDR) begin
            next_ctrl = reg_wdata;
        end
    end

    always_comb begin
        next_rdata = '0;
        if (reg_read) begin
            unique case (reg_addr)
                CTRL_ADDR: next_rdata = ctrl;
                STATUS_ADDR: next_rdata = status;
                CAPS_ADDR: next_rdata = {8'(TRIGGERS), 8'(TRIGGER_SIGNALS),
                    8'(CABLES), 8'(CABLE_SIGNALS)};
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
            reg_rdata <= '0;
        end else begin
            ctrl <= next_ctrl;
            reg_rdata <= next_rdata;
        end
    end

    // ---------------------------------------------------------------
    // cable links
    // ---------------------------------------------------------------
    logic [CABLES-1:0] cable_oe;
    logic [CABLES-1:0] cable_dir;

    for (genvar c = 0; c < CABLES; c++) begin : g_cable
        link_ctrl_if cable_if();
        // base fpga is the only party on a cable
        assign cable_if.permit = permit_s;
        assign cable_if.grant = base_ok;
        assign cable_if.req = {1'b0, base_cable_req_s[c]};
        assign cable_oe[c] = cable_if.oe;
        assign cable_dir[c] = cable_if.cfg[CFG_RECEIVE_BIT];
        link_sequencer #(.GUARD(GUARD)) u_seq (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .link(cable_if)
        );
    end

    // ---------------------------------------------------------------
    // trigger connectors
    // ---------------------------------------------------------------
    logic [TRIGGERS-1:0] trig_oe;
    logic [TRIGGERS-1:0] trig_dir;
    logic [TRIGGERS-1:0] trig_owner;

    for (genvar t = 0; t < TRIGGERS; t++) begin : g_trig
        link_ctrl_if trig_if();
        logic want_topo;
        // software picks the owner; an owner change runs the same
        // break-before-make sequence as a direction change
        assign want_topo = ctrl[CTRL_TRIG_OWNER_LSB + t];
        assign trig_if.permit = permit_s;
        assign trig_if.grant = want_topo ? topo_ok : base_ok;
        assign trig_if.req = {want_topo,
            want_topo ? topo_trig_req_s[t] : base_trig_req_s[t]};
        assign trig_oe[t] = trig_if.oe;
        assign trig_dir[t] = trig_if.cfg[CFG_RECEIVE_BIT];
        assign trig_owner[t] = trig_if.cfg[CFG_OWNER_BIT];
        link_sequencer #(.GUARD(GUARD)) u_seq (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .link(trig_if)
        );
    end

    // ---------------------------------------------------------------
    // oversight and output registers
    // ---------------------------------------------------------------
    logic [CABLES-1:0] next_cable_dir;
    logic [CABLES-1:0] next_cable_en_n;
    logic [TRIGGERS-1:0] next_trig_dir;
    logic [TRIGGERS-1:0] next_trig_base_en_n;
    logic [TRIGGERS-1:0] next_trig_topo_en_n;
    logic next_ack_n;
    logic next_vme_xcvr_n;
    logic next_vme_adrs_n;
    logic next_timing_n;
    logic next_timing_reset_n;

    // directions and enables are registered together so that the one-cycle
    // gap the sequencer leaves between them survives to the pins
    always_comb begin
        next_cable_dir = cable_dir;
        next_cable_en_n = ~(cable_oe & {CABLES{permit_s}});
        next_trig_dir = trig_dir;
        next_trig_base_en_n = ~(trig_oe & ~trig_owner & {TRIGGERS{permit_s}});
        next_trig_topo_en_n = ~(trig_oe & trig_owner & {TRIGGERS{permit_s}});
        next_ack_n = !(permit_s && ctrl[CTRL_VME_ACK_BIT]
            && vme_acknowledge_request);
        next_vme_xcvr_n = !(permit_s && ctrl[CTRL_VME_XCVR_BIT]);
        next_vme_adrs_n = !(permit_s && ctrl[CTRL_VME_ADRS_BIT]);
        next_timing_n = !(permit_s && ctrl[CTRL_TIMING_BIT]);
        next_timing_reset_n = !(permit_s && ctrl[CTRL_TIMING_RESET_BIT]);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cable_transceiver_direction <= '1;
            cable_translator_direction <= '1;
            cable_translator_enable_n <= '1;
            trigger_transceiver_direction <= '1;
            trigger_translator_direction <= '1;
            trigger_base_translator_enable_n <= '1;
            trigger_topology_translator_enable_n <= '1;
            vme_acknowledge_drive_n <= 1'b1;
            vme_transceiver_enable_n <= 1'b1;
            vme_address_translator_enable_n <= 1'b1;
            timing_decoder_translator_enable_n <= 1'b1;
            timing_reset_translator_enable_n <= 1'b1;
        end else begin
            // fpga pins are expected to follow the same request
            cable_transceiver_direction <= next_cable_dir;
            cable_translator_direction <= next_cable_dir;
            cable_translator_enable_n <= next_cable_en_n;
            trigger_transceiver_direction <= next_trig_dir;
            trigger_translator_direction <= next_trig_dir;
            trigger_base_translator_enable_n <= next_trig_base_en_n;
            trigger_topology_translator_enable_n <= next_trig_topo_en_n;
            vme_acknowledge_drive_n <= next_ack_n;
            vme_transceiver_enable_n <= next_vme_xcvr_n;
            vme_address_translator_enable_n <= next_vme_adrs_n;
            timing_decoder_translator_enable_n <= next_timing_n;
            timing_reset_translator_enable_n <= next_timing_reset_n;
        end
    end

    // ---------------------------------------------------------------
    // status word
    // ---------------------------------------------------------------
    always_comb begin
        status = '0;
        status[STAT_PERMIT_BIT] = permit_s;
        status[STAT_BASE_READY_BIT] = base_ok;
        status[STAT_TOPO_READY_BIT] = topo_ok;
        status[STAT_CABLE_ACTIVE_LSB +: CABLES] = cable_oe;
        status[STAT_TRIG_ACTIVE_LSB +: TRIGGERS] = trig_oe;
        status[STAT_TRIG_OWNER_LSB +: TRIGGERS] = trig_owner;
        status[STAT_CABLE_DIR_LSB +: CABLES] = cable_dir;
        status[STAT_TRIG_DIR_LSB +: TRIGGERS] = trig_dir;
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_CABLE_PERMIT:
        assert property (!permit_s |=> cable_translator_enable_n == '1)
        else $error("cable translator enabled without permit");
    AST_TRIG_PERMIT:
        assert property (!permit_s |=> (trigger_base_translator_enable_n
            & trigger_topology_translator_enable_n) == '1)
        else $error("trigger translator enabled without permit");
    AST_ONE_DRIVER:
        assert property ((~trigger_base_translator_enable_n
            & ~trigger_topology_translator_enable_n) == '0)
        else $error("both fpgas enabled on one connector");
    AST_DIR_MATCH:
        assert property (cable_transceiver_direction == cable_translator_direction
            && trigger_transceiver_direction == trigger_translator_direction)
        else $error("transceiver and translator disagree");
    AST_BENIGN:
        assert property (!permit_s |=> vme_acknowledge_drive_n
            && vme_transceiver_enable_n && vme_address_translator_enable_n
            && timing_decoder_translator_enable_n
            && timing_reset_translator_enable_n)
        else $error("enable active without permit");
    AST_VME_ACK:
        assert property (permit_s && ctrl[CTRL_VME_ACK_BIT] && vme_acknowledge_request
            |=> !vme_acknowledge_drive_n)
        else $error("acknowledge not driven");
    AST_TOPO_GRANT:
        assert property (trigger_topology_translator_enable_n != '1 |-> $past(topo_ok, 2))
        else $error("topology fpga enabled while not ready");
    AST_BASE_GRANT:
        assert property ((cable_translator_enable_n & '1) != '1 |-> $past(base_ok, 2))
        else $error("base fpga enabled while not ready");

    for (genvar c = 0; c < CABLES; c++) begin : g_cable_chk
        AST_CABLE_DIR_REQ:
            assert property (!cable_translator_enable_n[c]
                |-> cable_transceiver_direction[c] == $past(base_cable_req_s[c], 2))
            else $error("cable direction differs from request");
    end

    // ownership is software's choice alone
    for (genvar t = 0; t < TRIGGERS; t++) begin : g_trig_chk
        AST_TRIG_DIR_REQ:
            assert property (!trigger_base_translator_enable_n[t]
                |-> trigger_transceiver_direction[t] == $past(base_trig_req_s[t], 2))
            else $error("trigger direction differs from request");

        AST_TRIG_BASE_OWNER:
            assert property (!trigger_base_translator_enable_n[t]
                |-> !$past(ctrl[CTRL_TRIG_OWNER_LSB + t], 2))
            else $error("base fpga on a topology connector");

        AST_TRIG_TOPO_OWNER:
            assert property (!trigger_topology_translator_enable_n[t]
                |-> $past(ctrl[CTRL_TRIG_OWNER_LSB + t], 2))
            else $error("topology fpga on a base connector");
    end

    // a shared crate line: released unless allowed
    AST_ACK_RELEASE:
        assert property (!ctrl[CTRL_VME_ACK_BIT] |=> vme_acknowledge_drive_n)
        else $error("acknowledge driven while not allowed");

    COV_CABLE_ON:
        cover property (permit_s ##1 cable_translator_enable_n != '1);
    COV_TOPO_ON:
        cover property (trigger_topology_translator_enable_n != '1);
    COV_OWNER_SWAP:
        cover property (trigger_base_translator_enable_n[0] == 1'b0
            ##[1:40] trigger_topology_translator_enable_n[0] == 1'b0);
    COV_ACK:
        cover property (!vme_acknowledge_drive_n);
    // vme transceiver enable switching off after being on, whether permit or its control bit fell
    COV_PERMIT_DROP:
        cover property (!vme_transceiver_enable_n ##1 vme_transceiver_enable_n);
endmodule : lvds_direction_manager

// >>> hw/lvds_direction_pkg.sv
package lvds_direction_pkg;
    // ---------------------------------------------------------------
    // link counts and widths
    // ---------------------------------------------------------------
    localparam int CABLE_COUNT = 3;
    localparam int TRIGGER_COUNT = 2;
    localparam int CABLE_SIGNALS = 27;
    localparam int TRIGGER_SIGNALS = 33;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int GUARD_NS = 20;
    localparam int GUARD_CYCLES = (GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;
    localparam logic [3:0] CAPS_ADDR = 4'h8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int CTRL_TRIG_OWNER_LSB = 0;
    localparam int CTRL_VME_XCVR_BIT = 2;
    localparam int CTRL_VME_ADRS_BIT = 3;
    localparam int CTRL_TIMING_BIT = 4;
    localparam int CTRL_TIMING_RESET_BIT = 5;
    localparam int CTRL_VME_ACK_BIT = 6;
    localparam int STAT_PERMIT_BIT = 0;
    localparam int STAT_BASE_READY_BIT = 1;
    localparam int STAT_TOPO_READY_BIT = 2;
    localparam int STAT_CABLE_ACTIVE_LSB = 4;
    localparam int STAT_TRIG_ACTIVE_LSB = 8;
    localparam int STAT_TRIG_OWNER_LSB = 10;
    localparam int STAT_CABLE_DIR_LSB = 12;
    localparam int STAT_TRIG_DIR_LSB = 16;

    // ---------------------------------------------------------------
    // link configuration word: owner and direction
    // ---------------------------------------------------------------
    typedef logic [1:0] link_cfg_t;
    localparam int CFG_OWNER_BIT = 1;
    localparam int CFG_RECEIVE_BIT = 0;
    localparam link_cfg_t CFG_RESET = 2'h1;

    typedef enum logic [1:0] {SEQ_OFF, SEQ_SETTLE, SEQ_ON} seq_state_t;
endpackage : lvds_direction_pkg

// >>> verif/fpga_partner.sv
`timescale 1ns/100ps
module fpga_partner
    import lvds_direction_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [CABLE_COUNT-1:0] cable_want_rx,
    input wire logic [TRIGGER_COUNT-1:0] base_want_rx,
    input wire logic [TRIGGER_COUNT-1:0] topo_want_rx,
    output logic [CABLE_COUNT-1:0] base_cable_input_request,
    output logic [TRIGGER_COUNT-1:0] base_trigger_input_request,
    output logic [TRIGGER_COUNT-1:0] topology_trigger_input_request,
    output logic [CABLE_COUNT-1:0] base_cable_pin_drive,
    output logic [TRIGGER_COUNT-1:0] base_trigger_pin_drive,
    output logic [TRIGGER_COUNT-1:0] topology_trigger_pin_drive
);
    // ---------------------------------------------------------------
    // request pins
    // ---------------------------------------------------------------
    // requests leave fpga flops, so they move just after a clock edge
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            base_cable_input_request <= '1;
            base_trigger_input_request <= '1;
            topology_trigger_input_request <= '1;
        end else begin
            base_cable_input_request <= cable_want_rx;
            base_trigger_input_request <= base_want_rx;
            topology_trigger_input_request <= topo_want_rx;
        end
    end

    // ---------------------------------------------------------------
    // pin direction
    // ---------------------------------------------------------------
    // pins drive only when the fpga itself asked to transmit
    assign base_cable_pin_drive = ~base_cable_input_request;
    assign base_trigger_pin_drive = ~base_trigger_input_request;
    assign topology_trigger_pin_drive = ~topology_trigger_input_request;
endmodule : fpga_partner

// >>> verif/lvds_direction_manager_bench.sv
`timescale 1ns/100ps
module lvds_direction_manager_bench;
    import lvds_direction_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic drive_permit = 1'b0;
    logic base_cfg = 1'b0;
    logic topo_present_n = 1'b1;
    logic topo_cfg = 1'b0;
    logic ack_req = 1'b0;
    logic [2:0] cable_want = 3'h7;
    logic [1:0] base_want = 2'h3;
    logic [1:0] topo_want = 2'h3;
    logic [2:0] cable_req, cable_drive, cable_dir, cable_xl_dir, cable_en_n;
    logic [1:0] btrig_req, ttrig_req, btrig_drive, ttrig_drive;
    logic [1:0] trig_dir, trig_xl_dir, trig_base_en_n, trig_topo_en_n;
    logic ack_n, vme_en_n, adrs_en_n, tim_en_n, tim_rst_en_n;
    logic [11:0] all_en_n;
    int err_count = 0;
    int check_count = 0;

    assign all_en_n = {cable_en_n, trig_base_en_n, trig_topo_en_n, ack_n, vme_en_n,
        adrs_en_n, tim_en_n, tim_rst_en_n};

    always #2 sys_clk = ~sys_clk;

    lvds_direction_manager #(.GUARD(1)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .drive_permit(drive_permit),
        .base_fpga_configured(base_cfg), .base_cable_input_request(cable_req),
        .base_trigger_input_request(btrig_req), .topology_fpga_present_n(topo_present_n),
        .topology_fpga_configured(topo_cfg), .topology_trigger_input_request(ttrig_req),
        .vme_acknowledge_request(ack_req), .cable_transceiver_direction(cable_dir),
        .cable_translator_direction(cable_xl_dir), .cable_translator_enable_n(cable_en_n),
        .trigger_transceiver_direction(trig_dir), .trigger_translator_direction(trig_xl_dir),
        .trigger_base_translator_enable_n(trig_base_en_n),
        .trigger_topology_translator_enable_n(trig_topo_en_n),
        .vme_acknowledge_drive_n(ack_n), .vme_transceiver_enable_n(vme_en_n),
        .vme_address_translator_enable_n(adrs_en_n),
        .timing_decoder_translator_enable_n(tim_en_n),
        .timing_reset_translator_enable_n(tim_rst_en_n));

    fpga_partner u_partner (.sys_clk(sys_clk), .rst_n(rst_n), .cable_want_rx(cable_want),
        .base_want_rx(base_want), .topo_want_rx(topo_want),
        .base_cable_input_request(cable_req), .base_trigger_input_request(btrig_req),
        .topology_trigger_input_request(ttrig_req), .base_cable_pin_drive(cable_drive),
        .base_trigger_pin_drive(btrig_drive), .topology_trigger_pin_drive(ttrig_drive));

    // ---------------------------------------------------------------
    // shared tasks: the register tasks start and end at a rising edge
    // ---------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    task automatic reg_wr(input logic [3:0] addr, input logic [31:0] data);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
        @(posedge sys_clk);
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] addr, output logic [31:0] data);
        reg_addr <= addr;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1;
        data = reg_rdata;
        @(posedge sys_clk);
    endtask : reg_rd

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic test_regs();
        logic [31:0] d;
        reg_rd(CAPS_ADDR, d);
        check("caps", d, {8'(TRIGGER_COUNT), 8'(TRIGGER_SIGNALS), 8'(CABLE_COUNT),
            8'(CABLE_SIGNALS)});
        reg_wr(CTRL_ADDR, 32'h0000_003C);
        reg_wr(STATUS_ADDR, 32'hFFFF_FFFF);
        reg_rd(CTRL_ADDR, d);
        check("ctrl", d, 32'h0000_003C);
        reg_rd(4'hC, d);
        check("unmapped", d, 32'h0000_0000);
        $display("register test done");
    endtask : test_regs

    task automatic test_cable();
        logic [2:0] pdir, pen;
        cable_want <= 3'h5;
        for (int n = 0; n < 40 && cable_en_n !== 3'h0; n++) @(posedge sys_clk);
        check("cable_en_n", 32'(cable_en_n), 32'h0);
        check("cable_dir", 32'(cable_dir), 32'h5);
        check("cable_pins", 32'(cable_drive), 32'({~cable_dir}));
        cable_want <= 3'h2;
        for (int i = 0; i < 30; i++) begin
            pdir = cable_dir;
            pen = cable_en_n;
            @(posedge sys_clk);
            #1;
            check("cable_pair", 32'(cable_xl_dir), 32'(cable_dir));
            check("cable_turn", 32'((cable_dir ^ pdir) & ~(pen & cable_en_n)), 32'h0);
        end
        check("cable_dir_new", 32'(cable_dir), 32'h2);
        check("cable_en_new", 32'(cable_en_n), 32'h0);
        @(posedge sys_clk);
        $display("cable test done");
    endtask : test_cable

    task automatic test_trigger();
        logic [31:0] d;
        topo_present_n <= 1'b0;
        topo_cfg <= 1'b1;
        base_want <= 2'h1;
        topo_want <= 2'h0;
        reg_wr(CTRL_ADDR, 32'h0000_0002);
        for (int n = 0; n < 40 && {trig_base_en_n, trig_topo_en_n} !== 4'h9; n++)
            @(posedge sys_clk);
        check("trig_base_en", 32'(trig_base_en_n), 32'h2);
        check("trig_topo_en", 32'(trig_topo_en_n), 32'h1);
        check("trig_overlap", 32'({~trig_base_en_n & ~trig_topo_en_n}), 32'h0);
        check("trig_dir", 32'(trig_dir), 32'h1);
        check("trig_pair", 32'(trig_xl_dir), 32'(trig_dir));
        check("trig_pins", 32'({btrig_drive[0], ttrig_drive[1]}),
            32'({~trig_dir[0], ~trig_dir[1]}));
        reg_rd(STATUS_ADDR, d);
        check("status", d, 32'h0001_2B77);
        topo_present_n <= 1'b1;
        for (int n = 0; n < 40 && trig_topo_en_n !== 2'h3; n++) @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
        check("absent_topo", 32'(trig_topo_en_n), 32'h3);
        check("no_fallback", 32'(trig_base_en_n), 32'h2);
        $display("trigger test done");
    endtask : test_trigger

    task automatic test_vme_and_permit();
        reg_wr(CTRL_ADDR, 32'h0000_007C);
        for (int n = 0; n < 40 && {vme_en_n, adrs_en_n, tim_en_n} !== 3'h0; n++)
            @(posedge sys_clk);
        check("vme_en", 32'({vme_en_n, adrs_en_n, tim_en_n, tim_rst_en_n}), 32'h0);
        check("ack_idle", 32'(ack_n), 32'h1);
        ack_req <= 1'b1;
        @(posedge sys_clk);
        #1;
        check("ack_drive", 32'(ack_n), 32'h0);
        @(posedge sys_clk);
        drive_permit <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        check("benign", 32'(all_en_n), 32'hFFF);
        @(posedge sys_clk);
        $display("vme and permit test done");
    endtask : test_vme_and_permit

    initial begin
        repeat (5000) @(posedge sys_clk);
        err_count++;
        $display("watchdog expired");
        conclude();
    end

    initial begin
        @(posedge sys_clk);
        #1;
        check("reset_en", 32'(all_en_n), 32'hFFF);
        check("reset_dir", 32'({cable_dir, trig_dir}), 32'h1F);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        test_regs();
        drive_permit <= 1'b1;
        base_cfg <= 1'b1;
        test_cable();
        test_trigger();
        test_vme_and_permit();
        conclude();
    end
endmodule : lvds_direction_manager_bench
